/* File: pkg/ptc_defs.vh */
// Constants for the top-level configuration register bank
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PTC_ADDR_SUPPLY     8'h0a
`define PTC_ADDR_PROTECT    8'h0b
`define PTC_ADDR_MODE       8'h0c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PTC_RST_SUPPLY      8'h89
`define PTC_RST_PROTECT     8'hce
`define PTC_RST_MODE        8'h01

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PTC_PREWARN_MSB     7
`define PTC_PREWARN_LSB     6
`define PTC_SRCSEL_MSB      5
`define PTC_SRCSEL_LSB      4
`define PTC_OVP_BIT         2
`define PTC_IUVLO_MSB       1
`define PTC_IUVLO_LSB       0
`define PTC_SUVLO_MSB       7
`define PTC_SUVLO_LSB       6
`define PTC_TSHD_MSB        4
`define PTC_TSHD_LSB        2
`define PTC_TWARN_MSB       1
`define PTC_TWARN_LSB       0
`define PTC_MODE_HI_BIT     4
`define PTC_MODE_LO_BIT     3
`define PTC_SRST_BIT        2
`define PTC_PKEY_MSB        1
`define PTC_PKEY_LSB        0

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define PTC_SRC_AUTO        2'h0
`define PTC_SRC_BATT        2'h1
`define PTC_SRC_INPUT       2'h2
`define PTC_SRC_NONE        2'h3
`define PTC_TSHD_RSVD       3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PTC_CLK_MHZ         40
`define PTC_CYCLE_OFF_NS    1000
`define PTC_CYCLE_OFF_CYC   ((`PTC_CYCLE_OFF_NS * `PTC_CLK_MHZ) / 1000)

`endif

/* File: hdl/ptc_sync2.v */
// Two-flop synchroniser for a two-bit level
`timescale 1ns/1ps
module ptc_sync2 (
    input  wire       core_clk_in,
    input  wire       resetn_in,
    input  wire [1:0] async_in,
    output reg  [1:0] sync_out
);
    reg [1:0] stage1;

    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stage1   <= 2'h0;
            sync_out <= 2'h0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

/* File: hdl/ptc_top_config_regs.v */
// Top-level configuration registers 0x0a..0x0c with decoded settings
//
// What this block does
// RQ1: Two-bit system rail prewarn level, reset 10, codes 3.3 to 3.6 V.
// RQ2: Two-bit rail source select, reset 00: auto, battery only, input only.
// RQ3: Source code 11 disconnects the rail from both supplies, test only.
// RQ4: One-bit input overvoltage level, reset 0: 5.50 V, 1: 6.0 V.
// RQ5: Two-bit input undervoltage level, reset 01, codes 2.9 to 3.5 V.
// RQ6: System rail undervoltage level in bits 7:6, reset 11, 2.4 to 2.7 V.
// RQ7: Three-bit thermal shutdown point, reset 011, 95 to 125 C, 111 reserved.
// RQ8: Two-bit die temperature warning level, reset 10, 75 to 90 C.
// RQ9: Mode comes from register bits or mode pins, chosen by pin enable.
// RQ10: With pin source off, mode equals the two register mode bits.
// RQ11: Writing 1 to soft reset returns all other bits to defaults.
// RQ12: Soft reset power-cycles all regulator outputs off then on.
// RQ13: Soft reset bit clears itself and always reads back as 0.
// RQ14: Two-bit power key long press time, reset 01, 4 to 16 s.
// RQ15: Mode pins are synchronised before being decoded into the mode.
`timescale 1ns/1ps
`include "ptc_defs.vh"
module ptc_top_config_regs (
    input  wire       core_clk_in,
    input  wire       resetn_in,
    input  wire       reg_wr_en_in,
    input  wire       reg_rd_en_in,
    input  wire [7:0] reg_addr_in,
    input  wire [7:0] reg_wdata_in,
    input  wire       pin_mode_source_enable_in,
    input  wire       mode_select_pin_high_in,
    input  wire       mode_select_pin_low_in,
    input  wire       input_above_battery_in,
    output reg  [7:0] reg_rdata_out,
    output reg        reg_rvalid_out,
    output reg  [1:0] system_rail_prewarn_level_out,
    output reg        system_rail_from_battery_out,
    output reg        system_rail_from_input_out,
    output reg        input_overvoltage_level_out,
    output reg  [1:0] input_undervoltage_level_out,
    output reg  [1:0] system_rail_undervoltage_level_out,
    output reg  [2:0] thermal_shutdown_point_out,
    output reg        thermal_shutdown_reserved_out,
    output reg  [1:0] die_temp_warning_level_out,
    output reg  [1:0] active_mode_out,
    output reg  [1:0] power_key_long_press_time_out,
    output reg        regulators_enable_out,
    output reg        soft_reset_busy_out
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    reg  [7:0] supply_threshold_config;
    reg  [7:0] protection_threshold_config;
    reg  [7:0] mode_and_reset_config;
    reg        soft_reset_request;
    reg [15:0] cycle_off_count;
    reg  [1:0] next_mode;
    reg        next_from_battery;
    reg        next_from_input;
    wire [1:0] pin_mode_sync;

    localparam integer OFF_COUNT  = `PTC_CYCLE_OFF_CYC;
    localparam [15:0]  OFF_CYCLES = OFF_COUNT[15:0];

    function [7:0] read_mux;
        input [7:0] addr;
        input [7:0] r0;
        input [7:0] r1;
        input [7:0] r2;
        begin
            case (addr)
                `PTC_ADDR_SUPPLY:  read_mux = r0;
                `PTC_ADDR_PROTECT: read_mux = r1;
                `PTC_ADDR_MODE:    read_mux = r2;
                default:           read_mux = 8'h00;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Mode pin synchroniser
    // ----------------------------------------------------------------
    ptc_sync2 u_mode_sync (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .async_in    ({mode_select_pin_high_in, mode_select_pin_low_in}),
        .sync_out    (pin_mode_sync)
    ); // RQ15

    // ----------------------------------------------------------------
    // Register writes and soft reset
    // ----------------------------------------------------------------
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            supply_threshold_config     <= `PTC_RST_SUPPLY;
            protection_threshold_config <= `PTC_RST_PROTECT;
            mode_and_reset_config       <= `PTC_RST_MODE;
            soft_reset_request          <= 1'b0;
        end else if (soft_reset_request) begin
            supply_threshold_config     <= `PTC_RST_SUPPLY; // RQ11
            protection_threshold_config <= `PTC_RST_PROTECT; // RQ11
            mode_and_reset_config       <= `PTC_RST_MODE; // RQ11
            soft_reset_request          <= 1'b0; // RQ13
        end else if (reg_wr_en_in) begin
            case (reg_addr_in)
                `PTC_ADDR_SUPPLY:
                    supply_threshold_config <= reg_wdata_in;
                `PTC_ADDR_PROTECT:
                    protection_threshold_config <= reg_wdata_in;
                `PTC_ADDR_MODE: begin
                    mode_and_reset_config <= reg_wdata_in
                        & ~(8'h01 << `PTC_SRST_BIT); // RQ13
                    soft_reset_request <= reg_wdata_in[`PTC_SRST_BIT]; // RQ11
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Regulator power cycle
    // ----------------------------------------------------------------
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cycle_off_count       <= 16'h0000;
            regulators_enable_out <= 1'b1;
            soft_reset_busy_out   <= 1'b0;
        end else if (soft_reset_request) begin
            cycle_off_count       <= OFF_CYCLES; // RQ12
            regulators_enable_out <= 1'b0; // RQ12
            soft_reset_busy_out   <= 1'b1;
        end else if (cycle_off_count != 16'h0000) begin
            cycle_off_count <= cycle_off_count - 16'h0001;
            if (cycle_off_count == 16'h0001) begin
                regulators_enable_out <= 1'b1; // RQ12
                soft_reset_busy_out   <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Decoding of settings
    // ----------------------------------------------------------------
    always @* begin
        if (pin_mode_source_enable_in)
            next_mode = pin_mode_sync; // RQ9
        else
            next_mode = {mode_and_reset_config[`PTC_MODE_HI_BIT],
                         mode_and_reset_config[`PTC_MODE_LO_BIT]}; // RQ10
        case (supply_threshold_config[`PTC_SRCSEL_MSB:`PTC_SRCSEL_LSB])
            `PTC_SRC_AUTO: begin
                next_from_input   = input_above_battery_in; // RQ2
                next_from_battery = ~input_above_battery_in;
            end
            `PTC_SRC_BATT: begin
                next_from_input   = 1'b0;
                next_from_battery = 1'b1; // RQ2
            end
            `PTC_SRC_INPUT: begin
                next_from_input   = 1'b1; // RQ2
                next_from_battery = 1'b0;
            end
            default: begin
                next_from_input   = 1'b0; // RQ3
                next_from_battery = 1'b0; // RQ3
            end
        endcase
    end

    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out                      <= 8'h00;
            reg_rvalid_out                     <= 1'b0;
            system_rail_prewarn_level_out      <= 2'h2;
            system_rail_from_battery_out       <= 1'b0;
            system_rail_from_input_out         <= 1'b0;
            input_overvoltage_level_out        <= 1'b0;
            input_undervoltage_level_out       <= 2'h1;
            system_rail_undervoltage_level_out <= 2'h3;
            thermal_shutdown_point_out         <= 3'h3;
            thermal_shutdown_reserved_out      <= 1'b0;
            die_temp_warning_level_out         <= 2'h2;
            active_mode_out                    <= 2'h0;
            power_key_long_press_time_out      <= 2'h1;
        end else begin
            reg_rvalid_out <= reg_rd_en_in;
            if (reg_rd_en_in)
                reg_rdata_out <= read_mux(reg_addr_in,
                    supply_threshold_config, protection_threshold_config,
                    mode_and_reset_config); // RQ13
            system_rail_prewarn_level_out <= // RQ1
                supply_threshold_config[`PTC_PREWARN_MSB:`PTC_PREWARN_LSB];
            system_rail_from_battery_out <= next_from_battery;
            system_rail_from_input_out   <= next_from_input;
            input_overvoltage_level_out  <=
                supply_threshold_config[`PTC_OVP_BIT]; // RQ4
            input_undervoltage_level_out <=
                supply_threshold_config[`PTC_IUVLO_MSB:`PTC_IUVLO_LSB]; // RQ5
            system_rail_undervoltage_level_out <= // RQ6
                protection_threshold_config[`PTC_SUVLO_MSB:`PTC_SUVLO_LSB];
            thermal_shutdown_point_out <= // RQ7
                protection_threshold_config[`PTC_TSHD_MSB:`PTC_TSHD_LSB];
            thermal_shutdown_reserved_out <=
                (protection_threshold_config[`PTC_TSHD_MSB:`PTC_TSHD_LSB]
                 == `PTC_TSHD_RSVD); // RQ7
            die_temp_warning_level_out <= // RQ8
                protection_threshold_config[`PTC_TWARN_MSB:`PTC_TWARN_LSB];
            active_mode_out <= next_mode;
            power_key_long_press_time_out <=
                mode_and_reset_config[`PTC_PKEY_MSB:`PTC_PKEY_LSB]; // RQ14
        end
    end

endmodule

/* File: bench/ptc_regs_checker.sv */
// Port assertions for the top-level configuration registers
`timescale 1ns/1ps
module ptc_regs_checker (
    input wire       core_clk_in,
    input wire       resetn_in,
    input wire       reg_wr_en_in,
    input wire       reg_rd_en_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire [7:0] reg_rdata_out,
    input wire       pin_mode_source_enable_in,
    input wire [1:0] system_rail_prewarn_level_out,
    input wire       system_rail_from_battery_out,
    input wire       system_rail_from_input_out,
    input wire       input_overvoltage_level_out,
    input wire [2:0] thermal_shutdown_point_out,
    input wire       thermal_shutdown_reserved_out,
    input wire [1:0] active_mode_out,
    input wire [1:0] power_key_long_press_time_out,
    input wire       regulators_enable_out,
    input wire       soft_reset_busy_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    wire wa = reg_wr_en_in && reg_addr_in == 8'h0a;
    wire sr = reg_wr_en_in && reg_addr_in == 8'h0c && reg_wdata_in[2];
    supply_fields_a:
    assert property (wa |-> ##2 {system_rail_prewarn_level_out,
        input_overvoltage_level_out} == {$past(reg_wdata_in[7:6], 2),
        $past(reg_wdata_in[2], 2)}) else $error("supply field wrong");
    shutdown_field_a:
    assert property (reg_wr_en_in && reg_addr_in == 8'h0b |-> ##2
        thermal_shutdown_point_out == $past(reg_wdata_in[4:2], 2))
        else $error("shutdown field wrong");
    reserved_flag_a:
    assert property (thermal_shutdown_reserved_out ==
        (thermal_shutdown_point_out == 3'h7)) else $error("reserved flag");
    rail_off_a:
    assert property (wa && reg_wdata_in[5:4] == 2'h3 |-> ##2
        !system_rail_from_battery_out && !system_rail_from_input_out)
        else $error("rail not disconnected");
    reg_mode_a:
    assert property ((reg_wr_en_in && reg_addr_in == 8'h0c && !sr)
        ##0 !pin_mode_source_enable_in [*3] |->
        active_mode_out == $past(reg_wdata_in[4:3], 2))
        else $error("register mode wrong");
    cycle_start_a:
    assert property (sr |-> ##2 soft_reset_busy_out && !regulators_enable_out)
        else $error("power cycle not started");
    cycle_span_a:
    assert property ($rose(soft_reset_busy_out) |-> soft_reset_busy_out [*8]
        ##[31:34] (!soft_reset_busy_out && regulators_enable_out))
        else $error("power cycle length wrong");
    reset_clear_a:
    assert property (reg_rd_en_in && reg_addr_in == 8'h0c |=>
        !reg_rdata_out[2]) else $error("soft reset bit reads 1");
    reset_defaults_a:
    assert property (sr |-> ##3 system_rail_prewarn_level_out == 2'h2 &&
        thermal_shutdown_point_out == 3'h3 &&
        power_key_long_press_time_out == 2'h1) else $error("no defaults");
endmodule
bind ptc_top_config_regs ptc_regs_checker chk (.*);

/* File: bench/ptc_host_model.sv */
// Host side register access driver
`timescale 1ns/1ps
module ptc_host (
    input  wire       clk,
    output reg        wr_en,
    output reg        rd_en,
    output reg  [7:0] addr,
    output reg  [7:0] wdata
);
    initial {wr_en, rd_en, addr, wdata} = 18'h0;
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            {addr, wdata, wr_en} = {a, d, 1'b1};
            @(negedge clk);
            wr_en = 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(negedge clk);
            {addr, rd_en} = {a, 1'b1};
            @(negedge clk);
            rd_en = 1'b0;
        end
    endtask
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the top-level configuration registers
`timescale 1ns/1ps
`include "ptc_defs.vh"
module tb_top;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       pin_en = 1'b0;
    logic [1:0] pins = 2'h0;
    logic       above = 1'b0;
    wire        wr_en, rd_en, rvalid, ovp, fb, fi, rsv, ren, busy;
    wire  [7:0] addr, wdata, rdata;
    wire  [1:0] pw, iu, su, tw, mode, pk;
    wire  [2:0] ts;
    int         fail_count = 0;
    int         num_checks = 0;
    int         k;
    logic [7:0] expq[$];
    logic [7:0] r0, r1, r2;
    initial forever #12.5 clk = ~clk;
    ptc_host host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata));
    ptc_top_config_regs DUT (.core_clk_in(clk), .resetn_in(rstn),
        .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .pin_mode_source_enable_in(pin_en),
        .mode_select_pin_high_in(pins[1]), .mode_select_pin_low_in(pins[0]),
        .input_above_battery_in(above), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .system_rail_prewarn_level_out(pw),
        .system_rail_from_battery_out(fb), .system_rail_from_input_out(fi),
        .input_overvoltage_level_out(ovp), .input_undervoltage_level_out(iu),
        .system_rail_undervoltage_level_out(su),
        .thermal_shutdown_point_out(ts), .thermal_shutdown_reserved_out(rsv),
        .die_temp_warning_level_out(tw), .active_mode_out(mode),
        .power_key_long_press_time_out(pk), .regulators_enable_out(ren),
        .soft_reset_busy_out(busy));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        begin
            num_checks++;
            if (seen !== exp) begin
                fail_count++;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            expq.push_back(e);
            host.rd(a);
        end
    endtask
    always @(posedge clk) if (rvalid === 1'b1)
        chk(rdata, expq.size() ? expq.pop_front() : 8'hxx);
    task decoded(input [7:0] a, input [7:0] b, input [7:0] c);
        logic [1:0] e;
        begin
            e = a[5:4] == 2'h0 ? (above ? 2'h1 : 2'h2) : ~a[5:4];
            repeat (2) @(negedge clk);
            chk({pw, 3'h0, ovp, iu}, a & 8'hc7);
            chk({su, 1'b0, ts, tw}, b & 8'hdf);
            chk({rsv, mode, pk},
                {b[4:2] == 3'h7, c[4:3], c[1:0]});
            chk({fb, fi}, e);
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #(25 * 20000);
        fail_count++;
        summarize;
    end
    initial begin
        r0 = $urandom(20735);
        repeat (8) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        decoded(`PTC_RST_SUPPLY, `PTC_RST_PROTECT, `PTC_RST_MODE);
        chk({ren, busy}, 8'h2);
        rd(`PTC_ADDR_SUPPLY, `PTC_RST_SUPPLY);
        rd(`PTC_ADDR_PROTECT, `PTC_RST_PROTECT);
        rd(`PTC_ADDR_MODE, `PTC_RST_MODE);
        rd(8'h0d, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 12; i++) begin
            {r0, r1, r2} = 24'($urandom) & 24'hffff_fb;
            above = 1'($urandom);
            if (i < 4) r0[5:4] = i[1:0];
            if (i == 4) r1[4:2] = 3'h7;
            host.wr(8'h0a, r0);
            host.wr(8'h0b, r1);
            host.wr(8'h0c, r2);
            host.wr(8'h0d, ~r0);
            decoded(r0, r1, r2);
            rd(8'h0a, r0);
            rd(8'h0b, r1);
            rd(8'h0c, r2);
        end
        $display("test register fields done");
        pin_en = 1'b1;
        for (int i = 0; i < 4; i++) begin
            pins = 2'($urandom);
            repeat (4) @(negedge clk);
            chk(mode, pins);
        end
        pin_en = 1'b0;
        $display("test mode pins done");
        host.wr(8'h0b, 8'h31);
        host.wr(8'h0c, 8'h04);
        repeat (2) @(negedge clk);
        chk({ren, busy}, 8'h1);
        for (k = 0; busy !== 1'b0 && k < 100; k++) @(negedge clk);
        chk({ren, busy}, 8'h2);
        decoded(`PTC_RST_SUPPLY, `PTC_RST_PROTECT, `PTC_RST_MODE);
        rd(8'h0b, `PTC_RST_PROTECT);
        rd(8'h0c, `PTC_RST_MODE);
        repeat (3) @(negedge clk);
        chk(8'(expq.size()), 8'h0);
        $display("test soft reset done");
        summarize;
    end
endmodule
